// >>> hw/evirq_event_irq.sv
// Purpose: interrupt enables, flags and request for an event routing unit
// Assumes: event and overrun inputs toggle once per occurrence
// Notes:   enables and flags share one layout, irq is registered
//
// Contract
// - overrun clear-view write one disables channel
// - event-detect set-view write one enables channel
// - overrun set-view write one enables channel
// - both views read back current enables
// - event-detect flag set on channel event
// - asynchronous channel never sets event-detect flag
// - overrun flag set on channel overrun
// - asynchronous channel never sets overrun flag
// - write one clears event-detect flag
// - write one clears overrun flag
// - flags and enables reset to zero
// - event-detect clear-view write one disables channel
`timescale 1ns/1ps
module evirq_event_irq
   import evirq_pkg::*;
#(
   parameter int NUM_CHANNELS = 8
) (
   input  wire logic                    clk,           // 40 MHz bus clock
   input  wire logic                    reset_n,       // async reset, active low
   input  wire logic                    ce,            // clock enable
   input  wire logic [EVIRQ_ADDR_W-1:0] addr,          // register byte address
   input  wire logic [EVIRQ_DATA_W-1:0] wrData,        // write data
   input  wire logic                    wrEn,          // write strobe
   input  wire logic                    rdEn,          // read strobe
   output logic      [EVIRQ_DATA_W-1:0] rdData,        // read data, next cycle
   input  wire logic [NUM_CHANNELS-1:0] eventToggle,   // toggles per event
   input  wire logic [NUM_CHANNELS-1:0] overrunToggle, // toggles per overrun
   input  wire logic [NUM_CHANNELS-1:0] asyncPath,     // channel uses async path
   output logic                         irq            // combined request
);
   localparam logic [7:0] CH_MASK = 8'((9'h001 << NUM_CHANNELS) - 9'h001);

   if (NUM_CHANNELS < 1 || NUM_CHANNELS > EVIRQ_MAX_CHANNELS) begin : g_bad_ch
      $error("evirq_event_irq: NUM_CHANNELS must be 1..8");
   end

   logic [7:0]              evdEn_q, evdEn_d;
   logic [7:0]              ovrEn_q, ovrEn_d;
   logic [EVIRQ_DATA_W-1:0] rdData_q, rdData_d;
   logic                    irq_q, irq_d;
   logic [7:0]              evdToggle8;
   logic [7:0]              ovrToggle8;
   logic [7:0]              async8;
   logic [15:0]             pulse;
   logic [15:0]             setVec;
   logic [15:0]             clearVec;
   logic [15:0]             flags;
   logic                    wrSet;
   logic                    wrClr;
   logic                    wrFlag;

   assign evdToggle8 = 8'(eventToggle);
   assign ovrToggle8 = 8'(overrunToggle);
   assign async8     = 8'(asyncPath);

   evirq_toggle_sync #(
      .WIDTH (16)
   ) u_sync (
      .clk      (clk),
      .reset_n  (reset_n),
      .ce       (ce),
      .toggleIn ({evdToggle8, ovrToggle8}),
      .pulseOut (pulse)
   );

   // asynchronous-path channels never raise flags
   assign setVec = pulse & ~{async8, async8} & {CH_MASK, CH_MASK};

   assign wrSet  = wrEn && (addr == EVIRQ_OFF_ENSET);
   assign wrClr  = wrEn && (addr == EVIRQ_OFF_ENCLR);
   assign wrFlag = wrEn && (addr == EVIRQ_OFF_FLAG);

   always_comb begin
      clearVec = 16'h0000;
      if (wrFlag) begin
         clearVec = {evirq_evd_field(wrData), evirq_ovr_field(wrData)};
      end
   end

   evirq_flag_bank #(
      .WIDTH (16)
   ) u_flags (
      .clk       (clk),
      .reset_n   (reset_n),
      .ce        (ce),
      .setPulse  (setVec),
      .clearMask (clearVec),
      .flags     (flags)
   );

   // enables: one shared store behind both views
   always_comb begin
      evdEn_d = evdEn_q;
      ovrEn_d = ovrEn_q;
      if (ce && wrSet) begin
         evdEn_d = evdEn_q | (evirq_evd_field(wrData) & CH_MASK);
         ovrEn_d = ovrEn_q | (evirq_ovr_field(wrData) & CH_MASK);
      end else if (ce && wrClr) begin
         evdEn_d = evdEn_q & ~evirq_evd_field(wrData);
         ovrEn_d = ovrEn_q & ~evirq_ovr_field(wrData);
      end
   end

   // read data stands only in the cycle after the strobe
   always_comb begin
      rdData_d = rdData_q;
      if (ce) begin
         rdData_d = EVIRQ_READ_IDLE;
         if (rdEn) begin
            case (addr)
               EVIRQ_OFF_ENCLR: begin
                  rdData_d = evirq_place(evdEn_q, ovrEn_q);
               end
               EVIRQ_OFF_ENSET: begin
                  rdData_d = evirq_place(evdEn_q, ovrEn_q);
               end
               EVIRQ_OFF_FLAG: begin
                  rdData_d = evirq_place(flags[15:8], flags[7:0]);
               end
               default: begin
                  rdData_d = EVIRQ_READ_IDLE;
               end
            endcase
         end
      end
   end

   always_comb begin
      irq_d = irq_q;
      if (ce) begin
         irq_d = |(flags & {evdEn_q, ovrEn_q});
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         evdEn_q  <= EVIRQ_EN_RESET;
         ovrEn_q  <= EVIRQ_EN_RESET;
         rdData_q <= EVIRQ_READ_IDLE;
         irq_q    <= 1'b0;
      end else begin
         evdEn_q  <= evdEn_d;
         ovrEn_q  <= ovrEn_d;
         rdData_q <= rdData_d;
         irq_q    <= irq_d;
      end
   end

   assign rdData = rdData_q;
   assign irq    = irq_q;

   // marks the first cycle after reset release
   logic afterReset_q;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         afterReset_q <= 1'b1;
      end else begin
         afterReset_q <= 1'b0;
      end
   end

   property p_ovr_clear;
      @(posedge clk) disable iff (!reset_n)
      ce && wrClr |=> (ovrEn_q & $past(evirq_ovr_field(wrData))) == 8'h00
                      && ((ovrEn_q ^ $past(ovrEn_q)) & ~$past(evirq_ovr_field(wrData))) == 8'h00;
   endproperty
   a_ovr_clear: assert property (p_ovr_clear)
      else $error("overrun enable clear misbehaved");

   property p_evd_set;
      @(posedge clk) disable iff (!reset_n)
      ce && wrSet |=> evdEn_q == ($past(evdEn_q) | ($past(evirq_evd_field(wrData)) & CH_MASK));
   endproperty
   a_evd_set: assert property (p_evd_set)
      else $error("event-detect enable set misbehaved");

   property p_ovr_set;
      @(posedge clk) disable iff (!reset_n)
      ce && wrSet |=> ovrEn_q == ($past(ovrEn_q) | ($past(evirq_ovr_field(wrData)) & CH_MASK));
   endproperty
   a_ovr_set: assert property (p_ovr_set)
      else $error("overrun enable set misbehaved");

   property p_read_enable;
      @(posedge clk) disable iff (!reset_n)
      ce && rdEn && (wrClr || wrSet || addr == EVIRQ_OFF_ENSET || addr == EVIRQ_OFF_ENCLR)
         |=> rdData_q == evirq_place($past(evdEn_q), $past(ovrEn_q));
   endproperty
   a_read_enable: assert property (p_read_enable)
      else $error("enable read-back mismatch");

   property p_evd_flag;
      @(posedge clk) disable iff (!reset_n)
      ce && (setVec[15:8] != 8'h00) |=>
         (flags[15:8] & $past(setVec[15:8])) == $past(setVec[15:8]);
   endproperty
   a_evd_flag: assert property (p_evd_flag)
      else $error("event-detect flag not set");

   property p_evd_async;
      @(posedge clk) disable iff (!reset_n)
      ce |=> (flags[15:8] & ~$past(flags[15:8]) & $past(async8)) == 8'h00;
   endproperty
   a_evd_async: assert property (p_evd_async)
      else $error("event-detect flag set on asynchronous channel");

   property p_ovr_flag;
      @(posedge clk) disable iff (!reset_n)
      ce && (setVec[7:0] != 8'h00) |=>
         (flags[7:0] & $past(setVec[7:0])) == $past(setVec[7:0]);
   endproperty
   a_ovr_flag: assert property (p_ovr_flag)
      else $error("overrun flag not set");

   property p_ovr_async;
      @(posedge clk) disable iff (!reset_n)
      ce |=> (flags[7:0] & ~$past(flags[7:0]) & $past(async8)) == 8'h00;
   endproperty
   a_ovr_async: assert property (p_ovr_async)
      else $error("overrun flag set on asynchronous channel");

   property p_evd_w1c;
      @(posedge clk) disable iff (!reset_n)
      ce && wrFlag && ((evirq_evd_field(wrData) & ~setVec[15:8]) != 8'h00) |=>
         (flags[15:8] & $past(evirq_evd_field(wrData) & ~setVec[15:8])) == 8'h00;
   endproperty
   a_evd_w1c: assert property (p_evd_w1c)
      else $error("event-detect flag not cleared");

   property p_ovr_w1c;
      @(posedge clk) disable iff (!reset_n)
      ce && wrFlag && ((evirq_ovr_field(wrData) & ~setVec[7:0]) != 8'h00) |=>
         (flags[7:0] & $past(evirq_ovr_field(wrData) & ~setVec[7:0])) == 8'h00;
   endproperty
   a_ovr_w1c: assert property (p_ovr_w1c)
      else $error("overrun flag not cleared");

   property p_reset_zero;
      @(posedge clk) disable iff (!reset_n)
      afterReset_q |-> (evdEn_q == 8'h00) && (ovrEn_q == 8'h00) && (flags == 16'h0000);
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("state not zero after reset");

   property p_evd_clear;
      @(posedge clk) disable iff (!reset_n)
      ce && wrClr |=> evdEn_q == ($past(evdEn_q) & ~$past(evirq_evd_field(wrData)));
   endproperty
   a_evd_clear: assert property (p_evd_clear)
      else $error("event-detect enable clear misbehaved");

   property p_irq_or;
      @(posedge clk) disable iff (!reset_n)
      ce |=> irq_q == (|($past(flags) & {$past(evdEn_q), $past(ovrEn_q)}));
   endproperty
   a_irq_or: assert property (p_irq_or)
      else $error("irq is not the OR of enabled flags");

   c_irq_rise: cover property (@(posedge clk) disable iff (!reset_n) $rose(irq_q));
   c_flag_clear: cover property (@(posedge clk) disable iff (!reset_n)
      ce && wrFlag && (flags != 16'h0000));
   c_set_clear_clash: cover property (@(posedge clk) disable iff (!reset_n)
      ce && ((setVec & clearVec) != 16'h0000));
   c_async_block: cover property (@(posedge clk) disable iff (!reset_n)
      ce && ((pulse & {async8, async8}) != 16'h0000));
endmodule

// >>> hw/evirq_flag_bank.sv
// Purpose: sticky interrupt flags, set by hardware, cleared by writing one
// Assumes: set and clear vectors are synchronous to clk
// Notes:   a set in the clearing cycle wins so no event is lost
`timescale 1ns/1ps
module evirq_flag_bank
   import evirq_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,       // bus clock
   input  wire logic             reset_n,   // async reset, active low
   input  wire logic             ce,        // clock enable
   input  wire logic [WIDTH-1:0] setPulse,  // hardware set, one cycle
   input  wire logic [WIDTH-1:0] clearMask, // write-one-to-clear mask
   output logic      [WIDTH-1:0] flags      // current flags
);
   logic [WIDTH-1:0] flags_q, flags_d;

   if (WIDTH < 1 || WIDTH > 16) begin : g_bad_width
      $error("evirq_flag_bank: WIDTH must be 1..16");
   end

   always_comb begin
      flags_d = flags_q;
      if (ce) begin
         flags_d = (flags_q & ~clearMask) | setPulse;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         flags_q <= WIDTH'(EVIRQ_FLAG_RESET);
      end else begin
         flags_q <= flags_d;
      end
   end

   assign flags = flags_q;

   property p_set_wins;
      @(posedge clk) disable iff (!reset_n)
      ce && ((setPulse & clearMask) != '0) |=>
         ((flags_q & $past(setPulse & clearMask)) == $past(setPulse & clearMask));
   endproperty
   a_set_wins: assert property (p_set_wins)
      else $error("flag set lost against a clear in the same cycle");
endmodule

// >>> hw/evirq_pkg.sv
// Purpose: constants and helpers for the event channel interrupt logic
// Assumes: 32-bit register port, byte offsets as listed below
// Notes:   field layout is event detect in 15:8, overrun in 7:0
package evirq_pkg;
   localparam int          EVIRQ_MAX_CHANNELS = 8;
   localparam int          EVIRQ_ADDR_W       = 8;
   localparam int          EVIRQ_DATA_W       = 32;
   localparam logic [7:0]  EVIRQ_OFF_ENCLR    = 8'h10;
   localparam logic [7:0]  EVIRQ_OFF_ENSET    = 8'h14;
   localparam logic [7:0]  EVIRQ_OFF_FLAG     = 8'h18;
   localparam int          EVIRQ_EVD_LSB      = 8;
   localparam int          EVIRQ_OVR_LSB      = 0;
   localparam logic [7:0]  EVIRQ_EN_RESET     = 8'h00;
   localparam logic [15:0] EVIRQ_FLAG_RESET   = 16'h0000;
   localparam logic [31:0] EVIRQ_READ_IDLE    = 32'h00000000;
   // edges from an event toggle to the flag being visible
   localparam int          EVIRQ_FLAG_LATENCY = 4;

   // places the two per-channel fields into a register word
   function automatic logic [31:0] evirq_place(input logic [7:0] evd,
                                               input logic [7:0] ovr);
      logic [31:0] w;
      w = EVIRQ_READ_IDLE;
      w[EVIRQ_EVD_LSB +: 8] = evd;
      w[EVIRQ_OVR_LSB +: 8] = ovr;
      return w;
   endfunction

   function automatic logic [7:0] evirq_evd_field(input logic [31:0] w);
      return w[EVIRQ_EVD_LSB +: 8];
   endfunction

   function automatic logic [7:0] evirq_ovr_field(input logic [31:0] w);
      return w[EVIRQ_OVR_LSB +: 8];
   endfunction
endpackage

// >>> hw/evirq_toggle_sync.sv
// Purpose: carries event toggles from the event domain as one-cycle pulses
// Assumes: each source toggles at most once per three enabled cycles
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module evirq_toggle_sync
   import evirq_pkg::*;
#(
   parameter int WIDTH = 16
) (
   input  wire logic             clk,      // bus clock
   input  wire logic             reset_n,  // async reset, active low
   input  wire logic             ce,       // clock enable
   input  wire logic [WIDTH-1:0] toggleIn, // one toggle per event
   output logic      [WIDTH-1:0] pulseOut  // one-cycle pulse per toggle
);
   logic [WIDTH-1:0] meta_q, meta_d;
   logic [WIDTH-1:0] sync_q, sync_d;
   logic [WIDTH-1:0] last_q, last_d;
   logic [WIDTH-1:0] pulse_q, pulse_d;

   if (WIDTH < 1) begin : g_bad_width
      $error("evirq_toggle_sync: WIDTH must be at least 1");
   end

   always_comb begin
      meta_d  = meta_q;
      sync_d  = sync_q;
      last_d  = last_q;
      pulse_d = pulse_q;
      if (ce) begin
         meta_d  = toggleIn;
         sync_d  = meta_q;
         last_d  = sync_q;
         pulse_d = sync_q ^ last_q;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         meta_q  <= '0;
         sync_q  <= '0;
         last_q  <= '0;
         pulse_q <= '0;
      end else begin
         meta_q  <= meta_d;
         sync_q  <= sync_d;
         last_q  <= last_d;
         pulse_q <= pulse_d;
      end
   end

   assign pulseOut = pulse_q;

   property p_toggle_pulse;
      @(posedge clk) disable iff (!reset_n)
      (ce && (toggleIn != $past(toggleIn))) ##1 ce ##1 ce |=> (pulse_q != '0);
   endproperty
   a_toggle_pulse: assert property (p_toggle_pulse)
      else $error("toggle did not reach a pulse in three cycles");
endmodule

// >>> test/evirq_event_irq_tb.sv
// Purpose: self-checking bench for the event channel interrupt logic
// Assumes: default eight channels, register reads answer one cycle after the strobe
// Notes:   each scenario is a task that drives the ports and judges the answers
`timescale 1ns/1ps
module evirq_event_irq_tb
   import evirq_pkg::*;
;
   logic                    clk;
   logic                    reset_n;
   logic                    ce;
   logic [EVIRQ_ADDR_W-1:0] addr;
   logic [EVIRQ_DATA_W-1:0] wrData;
   logic                    wrEn;
   logic                    rdEn;
   logic [EVIRQ_DATA_W-1:0] rdData;
   logic [7:0]              eventToggle;
   logic [7:0]              overrunToggle;
   logic [7:0]              asyncPath;
   logic                    irq;
   int                      nMismatch;
   int                      testsRun;

   evirq_event_irq dut (
      .clk           (clk),
      .reset_n       (reset_n),
      .ce            (ce),
      .addr          (addr),
      .wrData        (wrData),
      .wrEn          (wrEn),
      .rdEn          (rdEn),
      .rdData        (rdData),
      .eventToggle   (eventToggle),
      .overrunToggle (overrunToggle),
      .asyncPath     (asyncPath),
      .irq           (irq)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         nMismatch++;
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr   <= a;
      wrData <= d;
      wrEn   <= 1'b1;
      @(posedge clk);
      wrEn   <= 1'b0;
   endtask

   // read data stand for one cycle only, then fall back to zero
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rdEn <= 1'b1;
      @(posedge clk);
      rdEn <= 1'b0;
      #1;
      chk("rdData", exp, rdData);
      @(posedge clk);
      #1;
      chk("rdData idle", 32'h00000000, rdData);
   endtask

   task automatic irqAfter(input int n, input logic exp);
      repeat (n) @(posedge clk);
      #1;
      chk("irq", {31'h0, exp}, {31'h0, irq});
   endtask

   task automatic pulse(input logic [7:0] ev, input logic [7:0] ov);
      @(posedge clk);
      eventToggle   <= eventToggle ^ ev;
      overrunToggle <= overrunToggle ^ ov;
      repeat (6) @(posedge clk);
   endtask

   task automatic t_reset();
      rd(EVIRQ_OFF_ENCLR, 32'h00000000);
      rd(EVIRQ_OFF_ENSET, 32'h00000000);
      rd(EVIRQ_OFF_FLAG, 32'h00000000);
      irqAfter(0, 1'b0);
      $display("test reset done");
   endtask

   task automatic t_enables();
      wr(EVIRQ_OFF_ENSET, 32'hffffffff);
      rd(EVIRQ_OFF_ENSET, 32'h0000ffff);
      rd(EVIRQ_OFF_ENCLR, 32'h0000ffff);
      wr(EVIRQ_OFF_ENSET, 32'h00000000);
      rd(EVIRQ_OFF_ENSET, 32'h0000ffff);
      wr(EVIRQ_OFF_ENCLR, 32'h00000000);
      rd(EVIRQ_OFF_ENCLR, 32'h0000ffff);
      wr(EVIRQ_OFF_ENCLR, 32'h000000a5);
      rd(EVIRQ_OFF_ENSET, 32'h0000ff5a);
      wr(EVIRQ_OFF_ENCLR, 32'h00005a00);
      rd(EVIRQ_OFF_ENCLR, 32'h0000a55a);
      wr(EVIRQ_OFF_ENCLR, 32'h0000ffff);
      rd(EVIRQ_OFF_ENSET, 32'h00000000);
      $display("test enables done");
   endtask

   task automatic t_flags();
      logic [7:0] m;
      m = 8'h00;
      for (int ch = 0; ch < 8; ch++) begin
         m[ch] = 1'b1;
         pulse(8'h01 << ch, 8'h01 << ch);
         rd(EVIRQ_OFF_FLAG, {16'h0000, m, m});
      end
      irqAfter(0, 1'b0);
      wr(EVIRQ_OFF_ENSET, 32'h00002000);
      irqAfter(2, 1'b1);
      wr(EVIRQ_OFF_ENCLR, 32'h00002000);
      irqAfter(2, 1'b0);
      wr(EVIRQ_OFF_FLAG, 32'h00000000);
      rd(EVIRQ_OFF_FLAG, 32'h0000ffff);
      wr(EVIRQ_OFF_ENSET, 32'h00000080);
      irqAfter(2, 1'b1);
      wr(EVIRQ_OFF_FLAG, 32'h000000ff);
      irqAfter(2, 1'b0);
      rd(EVIRQ_OFF_FLAG, 32'h0000ff00);
      wr(EVIRQ_OFF_FLAG, 32'h00000f00);
      rd(EVIRQ_OFF_FLAG, 32'h0000f000);
      wr(EVIRQ_OFF_FLAG, 32'h0000f000);
      rd(EVIRQ_OFF_FLAG, 32'h00000000);
      wr(EVIRQ_OFF_ENCLR, 32'h0000ffff);
      $display("test flags done");
   endtask

   task automatic t_async();
      @(posedge clk);
      asyncPath <= 8'h0f;
      pulse(8'hff, 8'hff);
      rd(EVIRQ_OFF_FLAG, 32'h0000f0f0);
      wr(EVIRQ_OFF_ENSET, 32'h00000f0f);
      irqAfter(2, 1'b0);
      wr(EVIRQ_OFF_FLAG, 32'h0000ffff);
      asyncPath <= 8'h00;
      pulse(8'h00, 8'h04);
      irqAfter(0, 1'b1);
      wr(EVIRQ_OFF_FLAG, 32'h00000004);
      wr(EVIRQ_OFF_ENCLR, 32'h0000ffff);
      rd(EVIRQ_OFF_FLAG, 32'h00000000);
      $display("test async done");
   endtask

   task automatic t_misc();
      wr(8'h1c, 32'hffffffff);
      rd(8'h1c, 32'h00000000);
      rd(8'h00, 32'h00000000);
      rd(EVIRQ_OFF_ENSET, 32'h00000000);
      @(posedge clk);
      ce <= 1'b0;
      wr(EVIRQ_OFF_ENSET, 32'h0000ffff);
      @(posedge clk);
      ce <= 1'b1;
      rd(EVIRQ_OFF_ENSET, 32'h00000000);
      $display("test misc done");
   endtask

   // set pulse meets a write-one clear in one cycle, then exact toggle-to-irq latency
   task automatic t_timing();
      @(posedge clk);
      eventToggle <= eventToggle ^ 8'h10;
      repeat (2) @(posedge clk);
      wr(EVIRQ_OFF_FLAG, 32'h00001000);
      rd(EVIRQ_OFF_FLAG, 32'h00001000);
      wr(EVIRQ_OFF_FLAG, 32'h00001000);
      rd(EVIRQ_OFF_FLAG, 32'h00000000);
      wr(EVIRQ_OFF_ENSET, 32'h00000002);
      @(posedge clk);
      overrunToggle <= overrunToggle ^ 8'h02;
      irqAfter(EVIRQ_FLAG_LATENCY, 1'b0);
      irqAfter(1, 1'b1);
      wr(EVIRQ_OFF_FLAG, 32'h00000002);
      wr(EVIRQ_OFF_ENCLR, 32'h0000ffff);
      rd(EVIRQ_OFF_FLAG, 32'h00000000);
      $display("test timing done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", testsRun, nMismatch);
      if (nMismatch == 0 && testsRun > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   initial begin
      #(20000 * 25);
      nMismatch++;
      results();
   end

   initial begin
      nMismatch     = 0;
      testsRun      = 0;
      reset_n       = 1'b0;
      ce            = 1'b1;
      addr          = 8'h00;
      wrData        = 32'h00000000;
      wrEn          = 1'b0;
      rdEn          = 1'b0;
      eventToggle   = 8'h00;
      overrunToggle = 8'h00;
      asyncPath     = 8'h00;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      t_reset();
      t_enables();
      t_flags();
      t_async();
      t_misc();
      t_timing();
      results();
   end
endmodule
